// [msu_top.sv]
// Multiword shift unit: word memory, shift engine and Avalon-MM register slave
//
// What this block does
// - Shift request bit 14 moves the whole range one bit, direction from bit 12.
// - Leftward: bit 13 enters bit 00 of first word, last bit 15 goes to carry.
// - Rightward: bit 13 enters bit 15 of last word, first bit 00 goes to carry.
// - Clear bit 15 zeroes range and carry and ignores the input bit.
// - Shifting happens only with clear off; clear wins over shift.
// - Bit and word shifts set fault when first address exceeds last, else clear it.
// - Carry holds the bit shifted out; an active clear forces it off.
// - Word shift moves words toward last, source into first, last word lost.
// - Arithmetic left shift inserts zero at bit 0, old top bit to carry.
// - Double left shift treats operand word and next word as one 32-bit value.
// - Arithmetic shifts set equals only when the result is zero.
// - Arithmetic shifts set negative when the result top bit is one.
// - Double shift puts zero in lower word bit 0, upper top bit to carry.
`timescale 1ns/1ps
`default_nettype none
module msu_top
#(
   parameter int ADDR_W = 8 // Word memory address width
)
(
   input wire logic clk, // System clock, 200 MHz
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic [5:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Byte lanes of a write
   output logic [31:0] avs_readdata, // Read data, registered
   output logic avs_waitrequest, // Stall of the current request
   output logic irq // Level interrupt
);
   import msu_pkg::*;

   localparam int DEPTH = 1 << ADDR_W;

   // ---------------------------------------------------------------
   // Parameter check
   // ---------------------------------------------------------------
   if (ADDR_W < 1 || ADDR_W > 16)
   begin : g_bad_addr_w
      $error("msu_top: ADDR_W must lie in 1..16");
   end

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [15:0] mem_r [DEPTH];
   msu_ctrl_t ctrl_r;
   logic [ADDR_W-1:0] start_r;
   logic [ADDR_W-1:0] end_r;
   logic [15:0] opnd_r;
   logic [ADDR_W-1:0] mem_addr_r;
   msu_flags_t flags_r;
   logic [1:0] irq_stat_r;
   logic [1:0] irq_mask_r;
   logic [1:0] irq_set;
   msu_state_t state_r;
   msu_op_t op_r;
   logic [ADDR_W-1:0] ptr_r;
   logic chain_r;
   logic ack_r;
   logic [31:0] rdata_nxt;
   logic req;
   logic busy;
   logic acc_wr;
   logic cmd_go;
   logic range_bad;
   logic at_stop;
   logic [ADDR_W-1:0] ptr_hi;
   logic [ADDR_W-1:0] ptr_prev;
   logic [15:0] cell_a_in;
   logic [15:0] cell_a_out;
   logic [15:0] cell_b_out;
   logic cell_a_cin;
   logic cell_a_dir;
   logic cell_a_cout;
   logic cell_b_cout;

   // ---------------------------------------------------------------
   // Byte-lane merge for 16-bit registers
   // ---------------------------------------------------------------
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
      logic [15:0] res;
      res = old;
      if (be[0])
      begin
         res[7:0] = wd[7:0];
      end
      if (be[1])
      begin
         res[15:8] = wd[15:8];
      end
      return res;
   endfunction

   // ---------------------------------------------------------------
   // Bus handshake
   // ---------------------------------------------------------------
   // Every access waits one cycle; all accesses stall while the engine runs,
   // so no command, register or memory write can land mid-operation
   assign req = avs_read | avs_write;
   assign busy = (state_r != MSU_ST_IDLE);
   assign avs_waitrequest = req & (busy | ~ack_r);
   assign acc_wr = avs_write & ~avs_waitrequest;
   assign cmd_go = acc_wr & (avs_address == MSU_OFF_CMD);

   // Ack pulses for one cycle, then drops so a held request is taken once
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_r <= 1'b0;
      end
      else
      begin
         ack_r <= req & ~busy & ~ack_r;
      end
   end

   // Read mux; unmapped offsets read as zero
   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      unique case (avs_address)
         MSU_OFF_CMD: rdata_nxt = {30'h0000_0000, op_r};
         MSU_OFF_CTRL: rdata_nxt = {16'h0000, ctrl_r};
         MSU_OFF_START: rdata_nxt[ADDR_W-1:0] = start_r;
         MSU_OFF_END: rdata_nxt[ADDR_W-1:0] = end_r;
         MSU_OFF_OPND: rdata_nxt = {16'h0000, opnd_r};
         MSU_OFF_FLAGS: rdata_nxt = {27'h0000000, busy, flags_r};
         MSU_OFF_IRQ_STAT: rdata_nxt = {30'h0000_0000, irq_stat_r};
         MSU_OFF_IRQ_MASK: rdata_nxt = {30'h0000_0000, irq_mask_r};
         MSU_OFF_MEM_ADDR: rdata_nxt[ADDR_W-1:0] = mem_addr_r;
         MSU_OFF_MEM_DATA: rdata_nxt = {16'h0000, mem_r[mem_addr_r]};
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   // Read data captured the cycle before waitrequest falls
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         avs_readdata <= 32'h0000_0000;
      end
      else if (avs_read & ~busy & ~ack_r)
      begin
         avs_readdata <= rdata_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_r <= msu_ctrl_t'(MSU_RST_WORD);
         start_r <= '0;
         end_r <= '0;
         opnd_r <= MSU_RST_WORD;
         mem_addr_r <= '0;
         irq_mask_r <= MSU_RST_IRQ;
         op_r <= MSU_OP_BIT;
      end
      else if (acc_wr)
      begin
         unique case (avs_address)
            MSU_OFF_CMD: op_r <= msu_op_t'(avs_writedata[1:0]);
            MSU_OFF_CTRL: ctrl_r <= msu_ctrl_t'(merge16(ctrl_r, avs_writedata, avs_byteenable));
            MSU_OFF_START: start_r <= avs_writedata[ADDR_W-1:0];
            MSU_OFF_END: end_r <= avs_writedata[ADDR_W-1:0];
            MSU_OFF_OPND: opnd_r <= merge16(opnd_r, avs_writedata, avs_byteenable);
            MSU_OFF_IRQ_MASK: irq_mask_r <= avs_writedata[1:0];
            MSU_OFF_MEM_ADDR: mem_addr_r <= avs_writedata[ADDR_W-1:0];
            default: op_r <= op_r;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Shift datapath
   // ---------------------------------------------------------------
   // A range with first above last is refused before any word moves
   assign range_bad = (start_r > end_r);
   assign ptr_hi = ptr_r + 1'b1;
   assign ptr_prev = ptr_r - 1'b1;

   // Bit shift walks first to last when leftward, last to first when rightward;
   // word shift always walks last to first so each word is read before it is lost
   always_comb
   begin
      at_stop = 1'b1;
      if (op_r == MSU_OP_BIT)
      begin
         at_stop = ctrl_r.dir_right ? (ptr_r == start_r) : (ptr_r == end_r);
      end
      else if (op_r == MSU_OP_WORD)
      begin
         at_stop = (ptr_r == start_r);
      end
   end

   // Arithmetic shifts feed zero; the bit shift feeds the running chain bit
   assign cell_a_in = mem_r[ptr_r];
   assign cell_a_cin = (op_r == MSU_OP_BIT) ? chain_r : 1'b0;
   assign cell_a_dir = (op_r == MSU_OP_BIT) ? ctrl_r.dir_right : 1'b0;

   msu_shift_cell u_cell_lo
   (
      .word_in(cell_a_in),
      .cin(cell_a_cin),
      .dir_right(cell_a_dir),
      .word_out(cell_a_out),
      .cout(cell_a_cout)
   );

   // Upper half of the double shift takes the lower word's top bit
   msu_shift_cell u_cell_hi
   (
      .word_in(mem_r[ptr_hi]),
      .cin(cell_a_cout),
      .dir_right(1'b0),
      .word_out(cell_b_out),
      .cout(cell_b_cout)
   );

   // ---------------------------------------------------------------
   // Engine sequencer and word memory
   // ---------------------------------------------------------------
   // Memory has a single writer here; bus writes only land while idle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem_r[i] <= MSU_RST_WORD;
         end
         state_r <= MSU_ST_IDLE;
         ptr_r <= '0;
         chain_r <= 1'b0;
         flags_r <= '0;
      end
      else
      begin
         unique case (state_r)
            MSU_ST_IDLE:
            begin
               if (acc_wr && avs_address == MSU_OFF_MEM_DATA)
               begin
                  mem_r[mem_addr_r] <= merge16(mem_r[mem_addr_r], avs_writedata,
                                               avs_byteenable);
               end
               if (cmd_go)
               begin
                  // Op code is latched by the same edge, so decode the bus value
                  unique case (msu_op_t'(avs_writedata[1:0]))
                     MSU_OP_BIT:
                     begin
                        flags_r.fault_flag <= range_bad;
                        // Clear ignores the input bit and overrides shift
                        chain_r <= ctrl_r.clear ? 1'b0 : ctrl_r.data_in;
                        ptr_r <= ctrl_r.dir_right ? end_r : start_r;
                        if (!range_bad && (ctrl_r.clear || ctrl_r.shift))
                        begin
                           state_r <= MSU_ST_RUN;
                        end
                        else
                        begin
                           state_r <= MSU_ST_DONE;
                        end
                     end
                     MSU_OP_WORD:
                     begin
                        flags_r.fault_flag <= range_bad;
                        ptr_r <= end_r;
                        state_r <= range_bad ? MSU_ST_DONE : MSU_ST_RUN;
                     end
                     default:
                     begin
                        ptr_r <= opnd_r[ADDR_W-1:0];
                        state_r <= MSU_ST_RUN;
                     end
                  endcase
               end
            end
            MSU_ST_RUN:
            begin
               unique case (op_r)
                  MSU_OP_BIT:
                  begin
                     if (ctrl_r.clear)
                     begin
                        mem_r[ptr_r] <= MSU_RST_WORD;
                     end
                     else
                     begin
                        mem_r[ptr_r] <= cell_a_out;
                     end
                     chain_r <= ctrl_r.clear ? 1'b0 : cell_a_cout;
                     if (at_stop)
                     begin
                        // Last bit out of the range, or zero under clear
                        flags_r.carry_flag <= ctrl_r.clear ? 1'b0 : cell_a_cout;
                     end
                  end
                  MSU_OP_WORD:
                  begin
                     mem_r[ptr_r] <= at_stop ? opnd_r : mem_r[ptr_prev];
                  end
                  MSU_OP_ASL:
                  begin
                     mem_r[ptr_r] <= cell_a_out;
                     flags_r.carry_flag <= cell_a_cout;
                     flags_r.fault_flag <= 1'b0;
                     flags_r.equals <= (cell_a_out == 16'h0000);
                     flags_r.negative <= cell_a_out[15];
                  end
                  MSU_OP_DASL:
                  begin
                     mem_r[ptr_r] <= cell_a_out;
                     mem_r[ptr_hi] <= cell_b_out;
                     flags_r.carry_flag <= cell_b_cout;
                     flags_r.fault_flag <= 1'b0;
                     flags_r.equals <= ({cell_b_out, cell_a_out} == 32'h0000_0000);
                     flags_r.negative <= cell_b_out[15];
                  end
               endcase
               if (at_stop)
               begin
                  state_r <= MSU_ST_DONE;
               end
               else if (op_r == MSU_OP_BIT && !ctrl_r.dir_right)
               begin
                  ptr_r <= ptr_hi;
               end
               else
               begin
                  ptr_r <= ptr_prev;
               end
            end
            MSU_ST_DONE:
            begin
               state_r <= MSU_ST_IDLE;
            end
            default:
            begin
               state_r <= MSU_ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Interrupts
   // ---------------------------------------------------------------
   // Completion and fault events both fire in the done cycle
   assign irq_set[MSU_IRQ_DONE_BIT] = (state_r == MSU_ST_DONE);
   assign irq_set[MSU_IRQ_FAULT_BIT] = (state_r == MSU_ST_DONE) & flags_r.fault_flag;

   // Write one to clear; a same-cycle event wins over the clear
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_stat_r <= MSU_RST_IRQ;
      end
      else
      begin
         if (acc_wr && avs_address == MSU_OFF_IRQ_STAT)
         begin
            irq_stat_r <= (irq_stat_r & ~avs_writedata[1:0]) | irq_set;
         end
         else
         begin
            irq_stat_r <= irq_stat_r | irq_set;
         end
      end
   end

   assign irq = |(irq_stat_r & irq_mask_r);

endmodule
`default_nettype wire

// [msu_pkg.sv]
// Shared constants, types and register map of the multiword shift unit
package msu_pkg;

   // ---------------------------------------------------------------
   // Register byte offsets on the Avalon-MM slave
   // ---------------------------------------------------------------
   localparam logic [5:0] MSU_OFF_CMD = 6'h00;
   localparam logic [5:0] MSU_OFF_CTRL = 6'h04;
   localparam logic [5:0] MSU_OFF_START = 6'h08;
   localparam logic [5:0] MSU_OFF_END = 6'h0c;
   localparam logic [5:0] MSU_OFF_OPND = 6'h10;
   localparam logic [5:0] MSU_OFF_FLAGS = 6'h14;
   localparam logic [5:0] MSU_OFF_IRQ_STAT = 6'h18;
   localparam logic [5:0] MSU_OFF_IRQ_MASK = 6'h1c;
   localparam logic [5:0] MSU_OFF_MEM_ADDR = 6'h20;
   localparam logic [5:0] MSU_OFF_MEM_DATA = 6'h24;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int MSU_CTRL_CLEAR_BIT = 15;
   localparam int MSU_CTRL_SHIFT_BIT = 14;
   localparam int MSU_CTRL_DATA_BIT = 13;
   localparam int MSU_CTRL_DIR_BIT = 12;
   localparam int MSU_IRQ_DONE_BIT = 0;
   localparam int MSU_IRQ_FAULT_BIT = 1;
   localparam logic [15:0] MSU_RST_WORD = 16'h0000;
   localparam logic [1:0] MSU_RST_IRQ = 2'h0;

   // Control word of the reversible bit shift; dir 1 means rightward
   typedef struct packed {
      logic clear;
      logic shift;
      logic data_in;
      logic dir_right;
      logic [11:0] unused;
   } msu_ctrl_t;

   // Condition flags, read back in the low nibble of the flags register
   typedef struct packed {
      logic negative;
      logic equals;
      logic fault_flag;
      logic carry_flag;
   } msu_flags_t;

   typedef enum logic [1:0] {
      MSU_OP_BIT = 2'b00,
      MSU_OP_WORD = 2'b01,
      MSU_OP_ASL = 2'b10,
      MSU_OP_DASL = 2'b11
   } msu_op_t;

   typedef enum logic [1:0] {
      MSU_ST_IDLE = 2'b00,
      MSU_ST_RUN = 2'b01,
      MSU_ST_DONE = 2'b10
   } msu_state_t;

endpackage

// [msu_shift_cell.sv]
// One-bit shift of a single 16-bit word with carry in and carry out
`timescale 1ns/1ps
`default_nettype none
module msu_shift_cell
(
   input wire logic [15:0] word_in, // Word before the shift
   input wire logic cin, // Bit entering the vacated end
   input wire logic dir_right, // 1 shifts toward bit 00
   output logic [15:0] word_out, // Word after the shift
   output logic cout // Bit leaving the word
);
   import msu_pkg::*;

   // ---------------------------------------------------------------
   // Shift network
   // ---------------------------------------------------------------
   // Leftward moves bit 15 out, rightward moves bit 00 out
   always_comb
   begin
      if (dir_right)
      begin
         word_out = {cin, word_in[15:1]};
         cout = word_in[0];
      end
      else
      begin
         word_out = {word_in[14:0], cin};
         cout = word_in[15];
      end
   end

endmodule
`default_nettype wire

// [msu_top_assertions.sv]
// Bus, flag and interrupt checks for the multiword shift unit
`timescale 1ns/1ps
`default_nettype none
module msu_top_assertions
import msu_pkg::*;
#(
   parameter int ADDR_W = 8 // Word memory address width
)
(
   input wire logic clk, // System clock
   input wire logic rst_n, // Async reset, active low
   input wire logic [5:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Byte lanes
   input wire logic [31:0] avs_readdata, // Read data
   input wire logic avs_waitrequest, // Stall
   input wire logic irq // Level interrupt
);
   logic [ADDR_W-1:0] first_r;
   logic [ADDR_W-1:0] last_r;
   logic [1:0] mask_r;
   logic fault_r;
   logic wr_ok;
   logic rd_ok;
   logic bad_range;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ----------------------------------------------------------------
   // Shadow of the range, mask and expected fault flag
   // ----------------------------------------------------------------
   assign wr_ok = avs_write && !avs_waitrequest;
   assign rd_ok = avs_read && !avs_waitrequest;
   assign bad_range = (first_r > last_r) && !avs_writedata[1];
   // Arith shifts always clear the fault, so only ops 0 and 1 can raise it
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         first_r <= '0;
         last_r <= '0;
         mask_r <= 2'h0;
         fault_r <= 1'b0;
      end
      else if (wr_ok)
      begin
         if (avs_address == MSU_OFF_START) first_r <= avs_writedata[ADDR_W-1:0];
         if (avs_address == MSU_OFF_END) last_r <= avs_writedata[ADDR_W-1:0];
         if (avs_address == MSU_OFF_IRQ_MASK) mask_r <= avs_writedata[1:0];
         if (avs_address == MSU_OFF_CMD) fault_r <= bad_range;
      end
   end

   sequence cmd_go;
      wr_ok && (avs_address == MSU_OFF_CMD);
   endsequence
   sequence flags_read;
      rd_ok && (avs_address == MSU_OFF_FLAGS);
   endsequence

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   a_idle_no_wait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("waitrequest high with no request");
   a_first_stall: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
      else $error("request answered in its first cycle");
   a_wait_bounded: assert property ($rose(avs_read || avs_write) |-> ##[1:600] !avs_waitrequest)
      else $error("request never answered");
   a_fault_read: assert property (flags_read |-> avs_readdata[1] == fault_r)
      else $error("fault flag does not match range");
   a_flags_upper: assert property (flags_read |-> avs_readdata[31:4] == 28'h0)
      else $error("busy or upper bits set on an idle flags read");
   a_mask_quiet: assert property (mask_r == 2'h0 |-> !irq)
      else $error("interrupt with all sources masked");
   a_fault_irq: assert property (cmd_go ##0 (bad_range && mask_r[1]) |-> ##[1:4] irq)
      else $error("fault did not raise interrupt");
   a_done_irq: assert property (cmd_go ##0 mask_r[0] |-> ##[1:600] irq)
      else $error("completion did not raise interrupt");
   a_unmapped_zero: assert property (rd_ok && avs_address >= 6'h28 |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
endmodule

bind msu_top msu_top_assertions #(.ADDR_W(ADDR_W)) msu_top_assertions_i (
   .clk(clk),
   .rst_n(rst_n),
   .avs_address(avs_address),
   .avs_read(avs_read),
   .avs_write(avs_write),
   .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest),
   .irq(irq)
);
`default_nettype wire

// [msu_seq_model.sv]
// Sequencer model that issues register accesses over Avalon-MM
`timescale 1ns/1ps
`default_nettype none
module msu_seq_model
import msu_pkg::*;
(
   input wire logic clk, // System clock
   input wire logic [31:0] avs_readdata, // Read data
   input wire logic avs_waitrequest, // Stall
   output logic [5:0] avs_address, // Byte address
   output logic avs_read, // Read request
   output logic avs_write, // Write request
   output logic [31:0] avs_writedata, // Write data
   output logic [3:0] avs_byteenable // Lanes, always all on
);
   // Quiet bus at time zero
   initial
   begin
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
   end

   // Write held until the edge that samples waitrequest low
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do
         @(posedge clk);
      while (avs_waitrequest);
      avs_write <= 1'b0;
   endtask

   // Read data taken at the same edge that ends the stall
   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_read <= 1'b1;
      do
         @(posedge clk);
      while (avs_waitrequest);
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask

   // Both ends always lie in the one word memory
   task automatic set_range(input logic [15:0] f, input logic [15:0] l);
      wr(MSU_OFF_START, {16'h0, f});
      wr(MSU_OFF_END, {16'h0, l});
   endtask
endmodule
`default_nettype wire

// [test_multiword_shift_unit.sv]
// Self-checking bench of the multiword shift unit
`timescale 1ns/1ps
`default_nettype none
module test_multiword_shift_unit;
import msu_pkg::*;
   logic clk;
   logic rst_n;
   logic [5:0] adr;
   logic rq;
   logic wq;
   logic [31:0] wdat;
   logic [3:0] be;
   logic [31:0] rdat;
   logic wait_q;
   logic irq;
   int fail_count = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [15:0] av [3] = '{16'h8000, 16'h4001, 16'h1234};
   logic [31:0] dv [3] = '{32'h7fff8001, 32'h80000000, 32'h0000c000};
   logic [15:0] r;
   logic [31:0] d;

   msu_top #(.ADDR_W(8)) msu_top_i (.clk(clk), .rst_n(rst_n), .avs_address(adr),
      .avs_read(rq), .avs_write(wq), .avs_writedata(wdat), .avs_byteenable(be),
      .avs_readdata(rdat), .avs_waitrequest(wait_q), .irq(irq));
   msu_seq_model msu_seq_model_i (.clk(clk), .avs_readdata(rdat), .avs_waitrequest(wait_q),
      .avs_address(adr), .avs_read(rq), .avs_write(wq), .avs_writedata(wdat),
      .avs_byteenable(be));

   // -------------------------------------------------------------------
   // Clock, timeout and reporting
   // -------------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Whole run needs well under a thousand cycles
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         give_verdict;
      end
   end

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("FAIL %0t value %h expected %h", $time, got, exp);
      end
   endtask

   // Irq is sampled mid-cycle, clear of edge updates
   task automatic chk_irq(input logic exp);
      @(negedge clk);
      checks_done++;
      if (irq !== exp)
      begin
         fail_count++;
         $display("FAIL %0t irq %b expected %b", $time, irq, exp);
      end
   endtask

   task automatic reg_is(input logic [5:0] a, input logic [31:0] exp);
      logic [31:0] got;
      msu_seq_model_i.rd(a, got);
      chk_val(got, exp);
   endtask

   task automatic mem_put(input logic [7:0] a, input logic [15:0] v);
      msu_seq_model_i.wr(MSU_OFF_MEM_ADDR, {24'h0, a});
      msu_seq_model_i.wr(MSU_OFF_MEM_DATA, {16'h0, v});
   endtask

   task automatic mem_is(input logic [7:0] a, input logic [15:0] exp);
      msu_seq_model_i.wr(MSU_OFF_MEM_ADDR, {24'h0, a});
      reg_is(MSU_OFF_MEM_DATA, {16'h0, exp});
   endtask

   // Later accesses stall until the engine is idle again
   task automatic run(input msu_op_t op, input logic [15:0] c);
      msu_seq_model_i.wr(MSU_OFF_CTRL, {16'h0, c});
      msu_seq_model_i.wr(MSU_OFF_CMD, {30'h0, op});
   endtask

   // -------------------------------------------------------------------
   // Test sequence
   // -------------------------------------------------------------------
   initial
   begin
      rst_n = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      reg_is(MSU_OFF_FLAGS, 32'h0);
      reg_is(MSU_OFF_IRQ_STAT, 32'h0);
      mem_is(8'h03, 16'h0000);
      reg_is(6'h3c, 32'h0);
      // Bit shift left and right over words 2..3, word 4 outside
      mem_put(8'h02, 16'h8001);
      mem_put(8'h03, 16'h4000);
      mem_put(8'h04, 16'hffff);
      msu_seq_model_i.set_range(16'h2, 16'h3);
      run(MSU_OP_BIT, 16'h6000);
      mem_is(8'h02, 16'h0003);
      mem_is(8'h03, 16'h8001);
      reg_is(MSU_OFF_FLAGS, 32'h0);
      run(MSU_OP_BIT, 16'h4000);
      mem_is(8'h03, 16'h0002);
      reg_is(MSU_OFF_FLAGS, 32'h1);
      run(MSU_OP_BIT, 16'h7000);
      mem_is(8'h02, 16'h0003);
      mem_is(8'h03, 16'h8001);
      reg_is(MSU_OFF_FLAGS, 32'h0);
      run(MSU_OP_BIT, 16'h5000);
      mem_is(8'h02, 16'h8001);
      reg_is(MSU_OFF_FLAGS, 32'h1);
      run(MSU_OP_BIT, 16'he000);
      mem_is(8'h02, 16'h0000);
      mem_is(8'h03, 16'h0000);
      reg_is(MSU_OFF_FLAGS, 32'h0);
      mem_is(8'h04, 16'hffff);
      // Reversed range raises the fault and its interrupt
      msu_seq_model_i.wr(MSU_OFF_IRQ_MASK, 32'h2);
      msu_seq_model_i.set_range(16'h5, 16'h4);
      mem_put(8'h05, 16'h1234);
      run(MSU_OP_BIT, 16'h4000);
      // The read is issued after the done cycle, so the status bits are set by then
      reg_is(MSU_OFF_FLAGS, 32'h2);
      chk_irq(1'b1);
      mem_is(8'h05, 16'h1234);
      reg_is(MSU_OFF_IRQ_STAT, 32'h3);
      msu_seq_model_i.wr(MSU_OFF_IRQ_STAT, 32'h3);
      reg_is(MSU_OFF_IRQ_STAT, 32'h0);
      chk_irq(1'b0);
      msu_seq_model_i.wr(MSU_OFF_OPND, 32'hbeef);
      msu_seq_model_i.wr(MSU_OFF_CMD, {30'h0, MSU_OP_WORD});
      reg_is(MSU_OFF_FLAGS, 32'h2);
      // Refused word shift left a sticky fault bit; clear it first
      msu_seq_model_i.wr(MSU_OFF_IRQ_STAT, 32'h3);
      // Word shift over 6..8; done is set but masked
      mem_put(8'h06, 16'h1111);
      mem_put(8'h07, 16'h2222);
      mem_put(8'h08, 16'h3333);
      msu_seq_model_i.set_range(16'h6, 16'h8);
      msu_seq_model_i.wr(MSU_OFF_CMD, {30'h0, MSU_OP_WORD});
      mem_is(8'h06, 16'hbeef);
      mem_is(8'h07, 16'h1111);
      mem_is(8'h08, 16'h2222);
      reg_is(MSU_OFF_FLAGS, 32'h0);
      chk_irq(1'b0);
      msu_seq_model_i.wr(MSU_OFF_IRQ_MASK, 32'h1);
      chk_irq(1'b1);
      msu_seq_model_i.wr(MSU_OFF_IRQ_STAT, 32'h1);
      // Single-word and double-word left shifts
      for (int i = 0; i < 3; i++)
      begin
         mem_put(8'h09, av[i]);
         msu_seq_model_i.wr(MSU_OFF_OPND, 32'h9);
         msu_seq_model_i.wr(MSU_OFF_CMD, {30'h0, MSU_OP_ASL});
         r = {av[i][14:0], 1'b0};
         mem_is(8'h09, r);
         reg_is(MSU_OFF_FLAGS, {28'h0, r[15], r == 16'h0, 1'b0, av[i][15]});
      end
      for (int i = 0; i < 3; i++)
      begin
         mem_put(8'h0a, dv[i][15:0]);
         mem_put(8'h0b, dv[i][31:16]);
         msu_seq_model_i.wr(MSU_OFF_OPND, 32'ha);
         msu_seq_model_i.wr(MSU_OFF_CMD, {30'h0, MSU_OP_DASL});
         d = {dv[i][30:0], 1'b0};
         mem_is(8'h0a, d[15:0]);
         mem_is(8'h0b, d[31:16]);
         reg_is(MSU_OFF_FLAGS, {28'h0, d[31], d == 32'h0, 1'b0, dv[i][31]});
      end
      give_verdict;
   end
endmodule
`default_nettype wire
